// *** dio_defs.vh ***
// Constants for the drive terminal block: register map, fields, timing.
// Assumes inclusion by dio_terminals.v only; definitions only.
`ifndef DIO_DEFS_VH
`define DIO_DEFS_VH

// ==========================================================
// Timing
`define DIO_CLK_HZ 50000000
`define DIO_STEP_MS 1
`define DIO_STEP_CYCLES (`DIO_CLK_HZ / 1000 * `DIO_STEP_MS)
`define DIO_DELAY_MAX_S 50
`define DIO_DELAY_MAX_MS (`DIO_DELAY_MAX_S * 1000)
`define DIO_DELAY_MAX_CNT 16'hc350
`define DIO_DELAY_RST 16'h0000

// ==========================================================
// Register byte offsets
`define DIO_OFS_VIRT_SEL 12'h000
`define DIO_OFS_VIRT_VAL 12'h004
`define DIO_OFS_IN_STATE 12'h008
`define DIO_OFS_FAULT_SNAP 12'h00c
`define DIO_OFS_OUT_SEL 12'h010
`define DIO_OFS_PULSE_HALF 12'h014
`define DIO_OFS_IRQ_STAT 12'h018
`define DIO_OFS_IRQ_MASK 12'h01c
`define DIO_OFS_OUT_STATE 12'h020
`define DIO_OFS_ON_DLY0 12'h040
`define DIO_OFS_OFF_DLY0 12'h060

// ==========================================================
// Fields and reset values
`define DIO_NUM_IN 6
`define DIO_OUT_SEL_W 17
`define DIO_FAST_MODE_BIT 16
`define DIO_IRQ_FAULT_BIT 6
`define DIO_IRQ_W 7
`define DIO_VIRT_RST 6'h00
`define DIO_OUT_SEL_RST 17'h00000
`define DIO_PULSE_HALF_RST 16'h0019
`define DIO_IRQ_MASK_RST 7'h00

// ==========================================================
// Output function codes
`define DIO_FN_NONE 4'h0
`define DIO_FN_RUN 4'h1
`define DIO_FN_FWD 4'h2
`define DIO_FN_REV 4'h3
`define DIO_FN_JOG 4'h4
`define DIO_FN_FAULT 4'h5
`define DIO_FN_FREQ_LEVEL_DETECT_ONE 4'h6
`define DIO_FN_FREQ_LEVEL_DETECT_TWO 4'h7
`define DIO_FN_REACHED 4'h8
`define DIO_FN_ZERO_SPD 4'h9
`define DIO_FN_UPPER 4'ha
`define DIO_FN_LOWER 4'hb
`define DIO_FN_READY 4'hc
`define DIO_FN_PREEXC 4'hd
`define DIO_FN_OVLD 4'he

`endif

// *** dio_terminals.v ***
// Drive terminal block: six conditioned inputs, four selectable outputs.
// Assumes one 50 MHz clock, APB master on the same clock, status from
// the drive core synchronous to pclk, field inputs asynchronous.

`include "dio_defs.vh"

module dio_terminals #(
   parameter STEP_CYCLES = `DIO_STEP_CYCLES
) (
   // Clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Field inputs, asynchronous
   input wire input_one,
   input wire input_two,
   input wire input_three,
   input wire input_four,
   input wire fast_input_a,
   input wire fast_input_b,
   // Drive core status, same clock
   input wire st_running,
   input wire st_forward,
   input wire st_reverse,
   input wire st_jogging,
   input wire st_freq_out_nz,
   input wire st_freq_ref_nz,
   input wire st_fault,
   input wire freq_level_detect_one,
   input wire freq_level_detect_two,
   input wire st_freq_reached,
   input wire st_at_upper,
   input wire st_at_lower,
   input wire st_main_pwr_ok,
   input wire st_ctrl_pwr_ok,
   input wire st_protect_act,
   input wire st_ready,
   input wire st_preexcite,
   input wire st_ovld_prealarm,
   // Conditioned input state for the core
   output reg [5:0] din_state,
   // Terminal outputs
   output reg relay_one,
   output reg relay_two,
   output reg open_coll_out,
   output reg fast_pulse_output,
   // Interrupt
   output reg irq
);

   // ==========================================================
   // Helpers

   function sel_cond;
      input [3:0] code;
      input [14:0] cond;
      begin
         if (code == `DIO_FN_NONE) begin
            sel_cond = 1'b0;
         end else begin
            sel_cond = cond[code - 4'h1];
         end
      end
   endfunction

   function [15:0] clamp_ms;
      input [31:0] v;
      begin
         if (v > `DIO_DELAY_MAX_MS) begin
            clamp_ms = `DIO_DELAY_MAX_CNT;
         end else begin
            clamp_ms = v[15:0];
         end
      end
   endfunction

   // ==========================================================
   // Input synchroniser, two stages; stage one read only by stage two

   reg [5:0] sync1_q;
   reg [5:0] sync2_q;
   wire [5:0] pin_in;
   assign pin_in = {fast_input_b, fast_input_a, input_four,
                    input_three, input_two, input_one};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else if (clk_en) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // ==========================================================
   // Registers

   reg [5:0] virt_sel_q;
   reg [5:0] virt_val_q;
   reg [16:0] out_sel_q;
   reg [15:0] pulse_half_q;
   reg [6:0] irq_stat_q;
   reg [6:0] irq_mask_q;
   reg [5:0] fault_snap_q;
   reg [15:0] on_dly_q [0:5];
   reg [15:0] off_dly_q [0:5];

   wire wr_en;
   wire rd_setup;
   wire [6:0] irq_set;
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_setup = psel & ~penable;

   // Delay slot decode: offsets 0x40..0x54 on, 0x60..0x74 off
   wire dly_on_hit;
   wire dly_off_hit;
   wire [2:0] dly_idx;
   assign dly_idx = paddr[4:2];
   assign dly_on_hit = (paddr[11:5] == `DIO_OFS_ON_DLY0 >> 5) &&
                       (paddr[1:0] == 2'b00) && (dly_idx < 3'd6);
   assign dly_off_hit = (paddr[11:5] == `DIO_OFS_OFF_DLY0 >> 5) &&
                        (paddr[1:0] == 2'b00) && (dly_idx < 3'd6);

   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         virt_sel_q <= `DIO_VIRT_RST;
         virt_val_q <= `DIO_VIRT_RST;
         out_sel_q <= `DIO_OUT_SEL_RST;
         pulse_half_q <= `DIO_PULSE_HALF_RST;
         irq_mask_q <= `DIO_IRQ_MASK_RST;
         for (i = 0; i < 6; i = i + 1) begin
            on_dly_q[i] <= `DIO_DELAY_RST;
            off_dly_q[i] <= `DIO_DELAY_RST;
         end
      end else if (clk_en && wr_en) begin
         case (paddr)
            `DIO_OFS_VIRT_SEL: virt_sel_q <= pwdata[5:0];
            `DIO_OFS_VIRT_VAL: virt_val_q <= pwdata[5:0];
            `DIO_OFS_OUT_SEL: out_sel_q <= pwdata[16:0];
            `DIO_OFS_PULSE_HALF: begin
               // Zero is ignored; it would toggle every cycle, the same as a half period of one
               if (pwdata[15:0] != 16'h0000) begin
                  pulse_half_q <= pwdata[15:0];
               end
            end
            `DIO_OFS_IRQ_MASK: irq_mask_q <= pwdata[6:0];
            default: begin
               if (dly_on_hit) begin
                  on_dly_q[dly_idx] <= clamp_ms(pwdata);
               end
               if (dly_off_hit) begin
                  off_dly_q[dly_idx] <= clamp_ms(pwdata);
               end
            end
         endcase
      end
   end

   // Sticky status; a set in the clearing cycle wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 7'h00;
      end else if (clk_en) begin
         if (wr_en && paddr == `DIO_OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[6:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
      end
   end

   // ==========================================================
   // Millisecond tick, shared by all delay timers

   reg [31:0] tick_cnt_q;
   reg tick_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else if (clk_en) begin
         if (tick_cnt_q >= STEP_CYCLES - 1) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
         end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // On/off delay per input

   wire [5:0] raw_in;
   assign raw_in = (virt_sel_q & virt_val_q) | (~virt_sel_q & sync2_q);

   reg [15:0] dly_cnt_q [0:5];
   reg [15:0] need_d [0:5];
   integer m;
   integer k;
   always @* begin
      for (m = 0; m < 6; m = m + 1)
         need_d[m] = raw_in[m] ? on_dly_q[m] : off_dly_q[m];
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_state <= 6'h00;
         for (k = 0; k < 6; k = k + 1) begin
            dly_cnt_q[k] <= 16'h0000;
         end
      end else if (clk_en) begin
         for (k = 0; k < 6; k = k + 1) begin
            if (raw_in[k] == din_state[k]) begin
               dly_cnt_q[k] <= 16'h0000;
            end else if (need_d[k] == 16'h0000) begin
               din_state[k] <= raw_in[k];
            end else if (tick_q) begin
               if (dly_cnt_q[k] + 16'h0001 >= need_d[k]) begin
                  din_state[k] <= raw_in[k];
                  dly_cnt_q[k] <= 16'h0000;
               end else begin
                  dly_cnt_q[k] <= dly_cnt_q[k] + 16'h0001;
               end
            end
         end
      end
   end

   // ==========================================================
   // Fault snapshot and events

   reg fault_q;
   reg [5:0] din_prev_q;
   wire fault_rise;
   assign fault_rise = st_fault & ~fault_q;
   assign irq_set = {fault_rise, din_state ^ din_prev_q};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= 1'b0;
         din_prev_q <= 6'h00;
         fault_snap_q <= 6'h00;
      end else if (clk_en) begin
         fault_q <= st_fault;
         din_prev_q <= din_state;
         if (fault_rise) begin
            fault_snap_q <= din_state;
         end
      end
   end

   // ==========================================================
   // Output function selection

   wire [14:0] cond;
   wire run_f;
   assign run_f = st_running & st_freq_out_nz;
   assign cond[0] = run_f;
   assign cond[1] = run_f & st_forward;
   assign cond[2] = run_f & st_reverse;
   assign cond[3] = run_f & st_jogging;
   assign cond[4] = st_fault;
   assign cond[5] = freq_level_detect_one;
   assign cond[6] = freq_level_detect_two;
   assign cond[7] = st_freq_reached;
   assign cond[8] = st_running & ~st_freq_out_nz & ~st_freq_ref_nz;
   assign cond[9] = st_at_upper;
   assign cond[10] = st_at_lower;
   assign cond[11] = st_main_pwr_ok & st_ctrl_pwr_ok &
                     ~st_protect_act & st_ready;
   assign cond[12] = st_preexcite;
   assign cond[13] = st_ovld_prealarm;
   assign cond[14] = 1'b0;

   // Same table for every output, so duplicate codes agree except the fast output in pulse mode
   wire fast_cond;
   assign fast_cond = sel_cond(out_sel_q[15:12], cond);

   // Pulse train runs while the condition holds
   reg [15:0] pulse_cnt_q;
   reg pulse_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt_q <= 16'h0000;
         pulse_q <= 1'b0;
      end else if (clk_en) begin
         if (!fast_cond) begin
            pulse_cnt_q <= 16'h0000;
            pulse_q <= 1'b0;
         end else if (pulse_cnt_q + 16'h0001 >= pulse_half_q) begin
            pulse_cnt_q <= 16'h0000;
            pulse_q <= ~pulse_q;
         end else begin
            pulse_cnt_q <= pulse_cnt_q + 16'h0001;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_one <= 1'b0;
         relay_two <= 1'b0;
         open_coll_out <= 1'b0;
         fast_pulse_output <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         relay_one <= sel_cond(out_sel_q[3:0], cond);
         relay_two <= sel_cond(out_sel_q[7:4], cond);
         open_coll_out <= sel_cond(out_sel_q[11:8], cond);
         if (out_sel_q[`DIO_FAST_MODE_BIT]) begin
            fast_pulse_output <= pulse_q;
         end else begin
            fast_pulse_output <= fast_cond;
         end
         irq <= |((irq_stat_q | irq_set) & irq_mask_q);
      end
   end

   // ==========================================================
   // APB read path; one wait-free access cycle

   reg [31:0] rd_d;
   reg hit_d;
   always @* begin
      rd_d = 32'h00000000;
      hit_d = 1'b1;
      case (paddr)
         `DIO_OFS_VIRT_SEL: rd_d = {26'h0, virt_sel_q};
         `DIO_OFS_VIRT_VAL: rd_d = {26'h0, virt_val_q};
         `DIO_OFS_IN_STATE: rd_d = {26'h0, din_state};
         `DIO_OFS_FAULT_SNAP: rd_d = {26'h0, fault_snap_q};
         `DIO_OFS_OUT_SEL: rd_d = {15'h0, out_sel_q};
         `DIO_OFS_PULSE_HALF: rd_d = {16'h0, pulse_half_q};
         `DIO_OFS_IRQ_STAT: rd_d = {25'h0, irq_stat_q};
         `DIO_OFS_IRQ_MASK: rd_d = {25'h0, irq_mask_q};
         `DIO_OFS_OUT_STATE: rd_d = {28'h0, fast_pulse_output,
                                     open_coll_out, relay_two, relay_one};
         default: begin
            if (dly_on_hit) begin
               rd_d = {16'h0, on_dly_q[dly_idx]};
            end else if (dly_off_hit) begin
               rd_d = {16'h0, off_dly_q[dly_idx]};
            end else begin
               hit_d = 1'b0;
            end
         end
      endcase
   end

   // Read-only registers ignore writes but answer without error
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= rd_setup;
         if (rd_setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_d;
            pslverr <= ~hit_d;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule // dio_terminals

// *** dio_chk.sv ***
// Checker for the drive terminal block, bound to its top module.
// Assumes selector writes land at the APB access edge.
module dio_chk (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   // Core status
   input wire st_running,
   input wire st_freq_out_nz,
   input wire st_freq_ref_nz,
   input wire st_fault,
   input wire st_main_pwr_ok,
   input wire st_ctrl_pwr_ok,
   input wire st_protect_act,
   input wire st_ready,
   // Outputs
   input wire [5:0] din_state,
   input wire relay_one,
   input wire relay_two,
   input wire open_coll_out,
   input wire fast_pulse_output
);
   // ==========
   // Shadow selector; outputs lag it by one edge
   logic [16:0] sel_q, sel_p_q;
   logic [5:0] snap_q;
   logic en_q, flt_q;
   wire wr_sel = clk_en && psel && penable && pready && pwrite;
   wire rd_snap = psel && penable && pready && !pwrite;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 17'h00000;
         sel_p_q <= 17'h00000;
         snap_q <= 6'h00;
         en_q <= 1'b0;
         flt_q <= 1'b0;
      end else begin
         en_q <= clk_en;
         sel_p_q <= sel_q;
         if (wr_sel && paddr == 12'h010) sel_q <= pwdata[16:0];
         if (clk_en) flt_q <= st_fault;
         if (clk_en && st_fault && !flt_q) snap_q <= din_state;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========
   // Properties
   property p_none;
      en_q && sel_p_q[3:0] == 4'h0 |-> !relay_one;
   endproperty
   a_none: assert property (p_none) else $error("code 0 on");
   property p_fault;
      en_q && sel_p_q[7:4] == 4'h5 |-> relay_two == $past(st_fault);
   endproperty
   a_fault: assert property (p_fault) else $error("fault code");
   property p_run;
      en_q && sel_p_q[11:8] == 4'h1 |->
         open_coll_out == ($past(st_running) && $past(st_freq_out_nz));
   endproperty
   a_run: assert property (p_run) else $error("run code");
   property p_zero;
      en_q && sel_p_q[3:0] == 4'h9 |-> relay_one == ($past(st_running)
         && !$past(st_freq_out_nz) && !$past(st_freq_ref_nz));
   endproperty
   a_zero: assert property (p_zero) else $error("zero speed code");
   property p_ready;
      en_q && sel_p_q[11:8] == 4'hc |-> open_coll_out == ($past(st_ready)
         && $past(st_main_pwr_ok) && $past(st_ctrl_pwr_ok)
         && !$past(st_protect_act));
   endproperty
   a_ready: assert property (p_ready) else $error("ready code");
   property p_dup;
      en_q && sel_p_q[3:0] == sel_p_q[7:4] |-> relay_one == relay_two;
   endproperty
   a_dup: assert property (p_dup) else $error("shared code differs");
   property p_lvl;
      en_q && sel_p_q[16:12] == 5'h05 |->
         fast_pulse_output == $past(st_fault);
   endproperty
   a_lvl: assert property (p_lvl) else $error("fast level mode");
   property p_snap;
      rd_snap && paddr == 12'h00c |-> prdata[5:0] == snap_q;
   endproperty
   a_snap: assert property (p_snap) else $error("fault snapshot");
endmodule // dio_chk

bind dio_terminals dio_chk u_chk (.pclk, .presetn, .clk_en, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .st_running,
   .st_freq_out_nz, .st_freq_ref_nz, .st_fault, .st_main_pwr_ok,
   .st_ctrl_pwr_ok, .st_protect_act, .st_ready, .din_state, .relay_one,
   .relay_two, .open_coll_out, .fast_pulse_output);

// *** dio_field_model.sv ***
// Field contacts and drive core status seen by the terminal block.
// Assumes bench commands; levels change just after a rising pclk.
module dio_field_model (
   // Clock
   input wire logic pclk,
   // Bench commands
   input wire logic [5:0] pin_cmd,
   input wire logic [17:0] st_cmd,
   // Toward the block
   output logic [5:0] pins = 6'h00,
   output logic [17:0] st = 18'h00000
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clean levels; bounce is the delay logic's job
   always @(posedge pclk) begin
      pins <= pin_cmd;
      st <= st_cmd;
   end
endmodule // dio_field_model

// *** tb_top.sv ***
// Self-checking bench for the drive terminal block.
// Assumes dio_terminals, the field model and the bound checker.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [5:0] pin_cmd = 6'h00, pins;
   logic [17:0] st_cmd = 18'h0, st;
   logic err, p;
   logic clk_en = 1'b1;
   wire [31:0] prdata;
   wire pready, pslverr, relay_one, relay_two, open_coll_out;
   wire fast_pulse_output, irq;
   wire [5:0] din_state;
   wire [3:0] outs = {relay_one, relay_two, open_coll_out, fast_pulse_output};
   int n_errors = 0, checked = 0, n;
   // Code, status word, level expected on every output
   logic [22:0] rows [20] = '{{4'h0, 18'h3ffff, 1'b0},
      {4'h1, 18'h11, 1'b1}, {4'h1, 18'h01, 1'b0}, {4'h2, 18'h13, 1'b1},
      {4'h3, 18'h15, 1'b1}, {4'h3, 18'h13, 1'b0}, {4'h4, 18'h19, 1'b1},
      {4'h5, 18'h40, 1'b1}, {4'h6, 18'h80, 1'b1}, {4'h7, 18'h100, 1'b1},
      {4'h8, 18'h200, 1'b1}, {4'h9, 18'h01, 1'b1}, {4'h9, 18'h21, 1'b0},
      {4'ha, 18'h400, 1'b1}, {4'hb, 18'h800, 1'b1},
      {4'hc, 18'hb000, 1'b1}, {4'hc, 18'hf000, 1'b0},
      {4'hd, 18'h10000, 1'b1}, {4'he, 18'h20000, 1'b1},
      {4'hf, 18'h3ffff, 1'b0}};

   always #10 pclk = ~pclk;

   dio_field_model i_fld (.pclk, .pin_cmd, .st_cmd, .pins, .st);
   dio_terminals #(.STEP_CYCLES(10)) i_dut (
      .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr,
      .input_one(pins[0]), .input_two(pins[1]), .input_three(pins[2]),
      .input_four(pins[3]), .fast_input_a(pins[4]), .fast_input_b(pins[5]),
      .st_running(st[0]), .st_forward(st[1]), .st_reverse(st[2]),
      .st_jogging(st[3]), .st_freq_out_nz(st[4]), .st_freq_ref_nz(st[5]),
      .st_fault(st[6]), .freq_level_detect_one(st[7]),
      .freq_level_detect_two(st[8]), .st_freq_reached(st[9]),
      .st_at_upper(st[10]), .st_at_lower(st[11]), .st_main_pwr_ok(st[12]),
      .st_ctrl_pwr_ok(st[13]), .st_protect_act(st[14]), .st_ready(st[15]),
      .st_preexcite(st[16]), .st_ovld_prealarm(st[17]), .din_state,
      .relay_one, .relay_two, .open_coll_out, .fast_pulse_output, .irq);

   // ==========
   // Tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   // Waits for pready without assuming a latency
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========
   // Sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk(err, 1'b1);
      for (int i = 0; i < 20; i++) begin
         st_cmd <= rows[i][18:1];
         apb(1'b1, 12'h010, {16'h0, {4{rows[i][22:19]}}});
         cyc(3);
         chk(outs, {4{rows[i][0]}});
      end
      // Fault low again so the later snapshot sees a fresh rise
      st_cmd <= 18'h0;
      pin_cmd <= 6'h01;
      apb(1'b1, 12'h004, 32'h2a);
      apb(1'b1, 12'h000, 32'h3e);
      cyc(4);
      chk(din_state, 6'h2b);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h2b);
      pin_cmd <= 6'h00;
      cyc(3);
      chk(din_state, 6'h2b);
      cyc(1);
      chk(din_state, 6'h2a);
      // Delays of 3 and 2 ticks, each tick 10 cycles here
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h040, 32'h3);
      apb(1'b1, 12'h060, 32'h2);
      pin_cmd <= 6'h01;
      cyc(15);
      chk(din_state[0], 1'b0);
      cyc(25);
      chk(din_state[0], 1'b1);
      pin_cmd <= 6'h00;
      cyc(8);
      chk(din_state[0], 1'b1);
      cyc(25);
      chk(din_state[0], 1'b0);
      apb(1'b1, 12'h064, 32'h10000);
      apb(1'b0, 12'h064, 32'h0);
      chk(rd, 32'hc350);
      // Fault snapshot and interrupt
      apb(1'b1, 12'h000, 32'h3e);
      apb(1'b1, 12'h01c, 32'h40);
      apb(1'b1, 12'h018, 32'h7f);
      st_cmd <= 18'h40;
      cyc(4);
      chk(irq, 1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h2a);
      apb(1'b1, 12'h01c, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      apb(1'b1, 12'h01c, 32'h40);
      cyc(2);
      chk(irq, 1'b1);
      apb(1'b1, 12'h018, 32'h40);
      cyc(2);
      chk(irq, 1'b0);
      // Pulse train at half period 4 while fault holds
      apb(1'b1, 12'h014, 32'h4);
      apb(1'b1, 12'h010, 32'h15000);
      n = 0;
      p = fast_pulse_output;
      repeat (40) begin
         @(posedge pclk);
         if (fast_pulse_output !== p) n++;
         p = fast_pulse_output;
      end
      chk(n inside {[9:11]}, 1'b1);
      apb(1'b1, 12'h010, 32'h5000);
      cyc(3);
      chk(fast_pulse_output, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h8);
      // Clock enable low holds the fast output
      @(posedge pclk);
      clk_en <= 1'b0;
      st_cmd <= 18'h0;
      cyc(4);
      chk(fast_pulse_output, 1'b1);
      @(posedge pclk);
      clk_en <= 1'b1;
      cyc(2);
      chk(fast_pulse_output, 1'b0);
      test_done;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      test_done;
   end
endmodule // tb_top
